// ===== logic/rftrb_consts.svh
/*
 * Constants of the tuning register bank and of its host sequencer.
 * Assumes it is included by bare name wherever a constant is used.
 */
`ifndef RFTRB_CONSTS_SVH
`define RFTRB_CONSTS_SVH

// ****************************************************************
// Widths.
// ****************************************************************
`define RFTRB_AW          8
`define RFTRB_DW          32
`define RFTRB_RAMP_W      88
`define RFTRB_RAMP_TOP_W  24
`define RFTRB_BANK_BIT    7

// ****************************************************************
// Link register offsets.
// ****************************************************************
`define RFTRB_OFS_TUNE3   8'h03
`define RFTRB_OFS_TUNE4   8'h04
`define RFTRB_OFS_TUNE5   8'h05
`define RFTRB_OFS_TUNE6   8'h06
`define RFTRB_OFS_STAT    8'h07
`define RFTRB_OFS_ID      8'h08
`define RFTRB_OFS_INIT    8'h0C
`define RFTRB_OFS_FEAT    8'h0D
`define RFTRB_OFS_RAMP    8'h0E

// ****************************************************************
// Reset values.
// ****************************************************************
`define RFTRB_RST_TUNE3   32'h0300_1200
`define RFTRB_RST_ZERO    32'h0000_0000
`define RFTRB_ID_DEFAULT  32'h0000_5A5A

// ****************************************************************
// Setup values.
// ****************************************************************
`define RFTRB_VAL_TUNE3       32'h0000_0004
`define RFTRB_VAL_T4_FAST     32'h437D_5D5F
`define RFTRB_VAL_T4_SLOW     32'h437D_6D5F
`define RFTRB_VAL_T4_SC_FAST  32'hC37D_5D5D
`define RFTRB_VAL_T4_SC_SLOW  32'hC37D_6D5D
`define RFTRB_VAL_T5_250K     32'h7410_6C9F
`define RFTRB_VAL_T5_1M       32'h1412_6C9F
`define RFTRB_VAL_T5_2M       32'h7411_4C9F
`define RFTRB_VAL_T6_1M       32'h0007_C022
`define RFTRB_VAL_T6_OTHER    32'h0007_C002
`define RFTRB_VAL_INIT        32'h0573_1200
`define RFTRB_VAL_FEAT_FAST   32'h0080_B434
`define RFTRB_VAL_FEAT_SLOW   32'h0080_B436
`define RFTRB_VAL_RAMP        88'hCF_EFBE_F7DF_7CF3_CF20_8104
`define RFTRB_SEQ_LAST        4'h8
`define RFTRB_SEQ_RAMP0       4'h6
`define RFTRB_SEQ_RAMP1       4'h7

// ****************************************************************
// Host software register offsets and fields.
// ****************************************************************
`define RFTRB_SW_CTRL     8'h00
`define RFTRB_SW_GO       8'h01
`define RFTRB_SW_RADDR    8'h02
`define RFTRB_SW_RWDATA   8'h03
`define RFTRB_SW_RCMD     8'h04
`define RFTRB_SW_RRDATA   8'h05
`define RFTRB_SW_STATUS   8'h06
`define RFTRB_CTRL_SC     2
`define RFTRB_RCMD_WR     0
`define RFTRB_RCMD_RD     1
`define RFTRB_RCMD_TOG    2
`define RFTRB_ST_BUSY     0
`define RFTRB_ST_BANK     1
`define RFTRB_ST_DONE     2
`define RFTRB_ST_ERR      3

`endif

// ===== logic/rftrb_dev.sv
/*
 * Device end: the tuning register bank with its bank-select status.
 * Assumes the host keeps the link order; bank zero lies outside on b0_*.
 */
`timescale 1ns/1ps
`include "rftrb_consts.svh"

module rftrb_dev #(
  parameter logic [31:0] IDENTITY_VALUE = `RFTRB_ID_DEFAULT  // Arbitrary value.
) (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  rftrb_if.dev                          lk,
  output logic      [`RFTRB_DW-1:0]     tune3,
  output logic      [`RFTRB_DW-1:0]     tune4,
  output logic      [`RFTRB_DW-1:0]     tune5,
  output logic      [`RFTRB_DW-1:0]     tune6,
  output logic      [`RFTRB_DW-1:0]     lock_init,
  output logic      [`RFTRB_DW-1:0]     feat_cfg,
  output logic      [`RFTRB_RAMP_W-1:0] ramp_word,
  output logic                          bank_select_status,
  output logic      [`RFTRB_AW-1:0]     b0_addr,
  output logic      [`RFTRB_DW-1:0]     b0_wdata,
  output logic                          b0_wr,
  output logic                          b0_rd,
  input  wire logic [`RFTRB_DW-1:0]     b0_rdata
);

  rftrb_pkg::rftrb_dev_s s_q;
  rftrb_pkg::rftrb_dev_s s_d;
  logic                  ramp_wr;

  // ****************************************************************
  // Ramp word assembly.
  // ****************************************************************
  assign ramp_wr = lk.lk_wr && s_q.bank_one && (lk.lk_addr == `RFTRB_OFS_RAMP);

  rftrb_ramp_asm u_ramp (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .wr_en     (ramp_wr),
    .clr       (lk.lk_tog),
    .wdata     (lk.lk_wdata),
    .ramp_word (ramp_word)
  );

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    s_d         = s_q;
    s_d.rvalid  = 1'b0;
    s_d.b0_wr   = 1'b0;
    s_d.b0_rd   = 1'b0;
    s_d.b0_pend = s_q.b0_rd;
    if (lk.lk_tog) begin
      s_d.bank_one = ~s_q.bank_one;
    end
    if (lk.lk_wr) begin
      if (s_q.bank_one) begin
        unique case (lk.lk_addr)
          `RFTRB_OFS_TUNE3: s_d.tune3 = lk.lk_wdata;
          `RFTRB_OFS_TUNE4: s_d.tune4 = lk.lk_wdata;
          `RFTRB_OFS_TUNE5: s_d.tune5 = lk.lk_wdata;
          `RFTRB_OFS_TUNE6: s_d.tune6 = lk.lk_wdata;
          `RFTRB_OFS_INIT:  s_d.init  = lk.lk_wdata;
          `RFTRB_OFS_FEAT:  s_d.feat  = lk.lk_wdata;
          default: begin
          end
        endcase
      end else begin
        s_d.b0_addr  = lk.lk_addr;
        s_d.b0_wdata = lk.lk_wdata;
        s_d.b0_wr    = 1'b1;
      end
    end
    if (lk.lk_rd) begin
      if (lk.lk_addr == `RFTRB_OFS_STAT) begin
        s_d.rdata                  = `RFTRB_RST_ZERO;
        s_d.rdata[`RFTRB_BANK_BIT] = s_q.bank_one;
        s_d.rvalid                 = 1'b1;
      end else if (s_q.bank_one) begin
        s_d.rdata  = (lk.lk_addr == `RFTRB_OFS_ID) ? IDENTITY_VALUE : `RFTRB_RST_ZERO;
        s_d.rvalid = 1'b1;
      end else begin
        s_d.b0_addr = lk.lk_addr;
        s_d.b0_rd   = 1'b1;
      end
    end
    if (s_q.b0_pend) begin
      s_d.rdata  = b0_rdata;
      s_d.rvalid = 1'b1;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_q       <= '0;
      s_q.tune3 <= `RFTRB_RST_TUNE3;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign lk.lk_rdata        = s_q.rdata;
  assign lk.lk_rvalid       = s_q.rvalid;
  assign tune3              = s_q.tune3;
  assign tune4              = s_q.tune4;
  assign tune5              = s_q.tune5;
  assign tune6              = s_q.tune6;
  assign lock_init          = s_q.init;
  assign feat_cfg           = s_q.feat;
  assign bank_select_status = s_q.bank_one;
  assign b0_addr            = s_q.b0_addr;
  assign b0_wdata           = s_q.b0_wdata;
  assign b0_wr              = s_q.b0_wr;
  assign b0_rd              = s_q.b0_rd;

endmodule : rftrb_dev

// ===== logic/rftrb_host.sv
/*
 * Host end: a setup sequencer and raw access port for the tuning bank.
 * Assumes software drives the plain register port on core_clk and the
 * device end answers reads with lk_rvalid.
 */
// The implementer's own choice: the strobed register port.
// Functional notes
// - tuning word three resets 0x0300_1200, loaded 4.
// - word four normal value per data rate.
// - word four single-carrier value per data rate.
// - word five value per data rate.
// - word six value, 1 Mbps differs.
// - status bit 7 shows selected bank.
// - host never touches reserved status bits; a raw write to 0x07 in bank one still goes out on the link.
// - identity word read-only, writes ignored.
// - lock-time word loaded with fixed value.
// - feature word value per data rate.
// - 88-bit ramp word loaded with fixed value.
// - host avoids unmapped addresses in this bank.
`timescale 1ns/1ps
`include "rftrb_consts.svh"

module rftrb_host (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic [`RFTRB_AW-1:0] sw_addr,
  input  wire logic [`RFTRB_DW-1:0] sw_wdata,
  input  wire logic                 sw_wr,
  input  wire logic                 sw_rd,
  output logic      [`RFTRB_DW-1:0] sw_rdata,
  rftrb_if.host                     lk
);

  rftrb_pkg::rftrb_hst_s s_q;
  rftrb_pkg::rftrb_hst_s s_d;
  logic                  raw_ok;

  // ****************************************************************
  // Setup step decode.
  // ****************************************************************
  function automatic rftrb_pkg::rftrb_addr_t step_addr(input logic [3:0] st);
    unique case (st)
      4'h0:    step_addr = `RFTRB_OFS_TUNE3;
      4'h1:    step_addr = `RFTRB_OFS_TUNE4;
      4'h2:    step_addr = `RFTRB_OFS_TUNE5;
      4'h3:    step_addr = `RFTRB_OFS_TUNE6;
      4'h4:    step_addr = `RFTRB_OFS_INIT;
      4'h5:    step_addr = `RFTRB_OFS_FEAT;
      default: step_addr = `RFTRB_OFS_RAMP;
    endcase
  endfunction : step_addr

  function automatic rftrb_pkg::rftrb_data_t step_data(
    input logic [3:0]            st,
    input rftrb_pkg::rftrb_rate_e rt,
    input logic                  sc
  );
    logic        slow;
    rftrb_pkg::rftrb_ramp_t ramp;
    slow = (rt == rftrb_pkg::rftrb_rate_250k);
    ramp = `RFTRB_VAL_RAMP;
    unique case (st)
      4'h0: step_data = `RFTRB_VAL_TUNE3;
      4'h1: begin
        if (!sc) begin
          step_data = slow ? `RFTRB_VAL_T4_SLOW : `RFTRB_VAL_T4_FAST;
        end else begin
          step_data = slow ? `RFTRB_VAL_T4_SC_SLOW : `RFTRB_VAL_T4_SC_FAST;
        end
      end
      4'h2: begin
        unique case (rt)
          rftrb_pkg::rftrb_rate_250k: step_data = `RFTRB_VAL_T5_250K;
          rftrb_pkg::rftrb_rate_2m:   step_data = `RFTRB_VAL_T5_2M;
          default:                    step_data = `RFTRB_VAL_T5_1M;
        endcase
      end
      4'h3: step_data = (rt == rftrb_pkg::rftrb_rate_2m || slow) ?
                        `RFTRB_VAL_T6_OTHER : `RFTRB_VAL_T6_1M;
      4'h4: step_data = `RFTRB_VAL_INIT;
      4'h5: step_data = slow ? `RFTRB_VAL_FEAT_SLOW : `RFTRB_VAL_FEAT_FAST;
      `RFTRB_SEQ_RAMP0: step_data = ramp[`RFTRB_DW-1:0];
      `RFTRB_SEQ_RAMP1: step_data = ramp[2*`RFTRB_DW-1:`RFTRB_DW];
      default: step_data = {8'h00, ramp[`RFTRB_RAMP_W-1:2*`RFTRB_DW]};
    endcase
  endfunction : step_data

  // ****************************************************************
  // Raw access check.
  // ****************************************************************
  // refuse unmapped addresses while bank one is selected; bank zero takes any address.
  assign raw_ok = !s_q.bank_one || rftrb_pkg::rftrb_mapped(s_q.raddr);

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    s_d          = s_q;
    s_d.wr       = 1'b0;
    s_d.rd       = 1'b0;
    s_d.tog      = 1'b0;
    s_d.sw_rdata = `RFTRB_RST_ZERO;

    if (sw_wr) begin
      unique case (sw_addr)
        `RFTRB_SW_CTRL: begin
          s_d.rate = rftrb_pkg::rftrb_rate_e'(sw_wdata[1:0]);
          s_d.sc   = sw_wdata[`RFTRB_CTRL_SC];
        end
        `RFTRB_SW_GO: begin
          if (s_q.state == rftrb_pkg::hs_idle) begin
            s_d.state = rftrb_pkg::hs_chk_rd;
            s_d.done  = 1'b0;
          end
        end
        `RFTRB_SW_RADDR:  s_d.raddr  = sw_wdata[`RFTRB_AW-1:0];
        `RFTRB_SW_RWDATA: s_d.rwdata = sw_wdata;
        `RFTRB_SW_STATUS: begin
          if (sw_wdata[`RFTRB_ST_ERR]) begin
            s_d.err = 1'b0;
          end
        end
        `RFTRB_SW_RCMD: begin
          if (s_q.state == rftrb_pkg::hs_idle) begin
            if (sw_wdata[`RFTRB_RCMD_TOG]) begin
              s_d.tog      = 1'b1;
              s_d.bank_one = ~s_q.bank_one;
            end else if (!raw_ok && (sw_wdata[`RFTRB_RCMD_WR] || sw_wdata[`RFTRB_RCMD_RD])) begin
              s_d.err = 1'b1;
            end else if (sw_wdata[`RFTRB_RCMD_WR]) begin
              s_d.addr  = s_q.raddr;
              s_d.wdata = s_q.rwdata;
              s_d.wr    = 1'b1;
            end else if (sw_wdata[`RFTRB_RCMD_RD]) begin
              s_d.addr  = s_q.raddr;
              s_d.rd    = 1'b1;
              s_d.state = rftrb_pkg::hs_raw_wait;
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (sw_rd) begin
      unique case (sw_addr)
        `RFTRB_SW_CTRL: begin
          s_d.sw_rdata[1:0]          = s_q.rate;
          s_d.sw_rdata[`RFTRB_CTRL_SC] = s_q.sc;
        end
        `RFTRB_SW_RADDR:  s_d.sw_rdata[`RFTRB_AW-1:0] = s_q.raddr;
        `RFTRB_SW_RWDATA: s_d.sw_rdata = s_q.rwdata;
        `RFTRB_SW_RRDATA: s_d.sw_rdata = s_q.rrdata;
        `RFTRB_SW_STATUS: begin
          s_d.sw_rdata[`RFTRB_ST_BUSY] = (s_q.state != rftrb_pkg::hs_idle);
          s_d.sw_rdata[`RFTRB_ST_BANK] = s_q.bank_one;
          s_d.sw_rdata[`RFTRB_ST_DONE] = s_q.done;
          s_d.sw_rdata[`RFTRB_ST_ERR]  = s_q.err;
        end
        default: begin
        end
      endcase
    end

    unique case (s_q.state)
      rftrb_pkg::hs_idle: begin
      end
      rftrb_pkg::hs_chk_rd: begin
        s_d.addr  = `RFTRB_OFS_STAT;
        s_d.rd    = 1'b1;
        s_d.state = rftrb_pkg::hs_chk_wait;
      end
      rftrb_pkg::hs_chk_wait: begin
        if (lk.lk_rvalid) begin
          // only the bank bit is used.
          s_d.bank_one = 1'b1;
          s_d.tog      = ~lk.lk_rdata[`RFTRB_BANK_BIT];
          s_d.step     = 4'h0;
          s_d.state    = rftrb_pkg::hs_seq;
        end
      end
      rftrb_pkg::hs_seq: begin
        s_d.addr  = step_addr(s_q.step);
        s_d.wdata = step_data(s_q.step, s_q.rate, s_q.sc);
        s_d.wr    = 1'b1;
        s_d.step  = s_q.step + 4'h1;
        if (s_q.step == `RFTRB_SEQ_LAST) begin
          s_d.state = rftrb_pkg::hs_idle;
          s_d.done  = 1'b1;
        end
      end
      rftrb_pkg::hs_raw_wait: begin
        if (lk.lk_rvalid) begin
          s_d.rrdata = lk.lk_rdata;
          s_d.state  = rftrb_pkg::hs_idle;
        end
      end
    endcase
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign sw_rdata    = s_q.sw_rdata;
  assign lk.lk_addr  = s_q.addr;
  assign lk.lk_wdata = s_q.wdata;
  assign lk.lk_wr    = s_q.wr;
  assign lk.lk_rd    = s_q.rd;
  assign lk.lk_tog   = s_q.tog;

endmodule : rftrb_host

// ===== logic/rftrb_if.sv
/*
 * Link between the host sequencer and the tuning register bank.
 * Assumes both ends run on the same core_clk.
 */
`timescale 1ns/1ps

interface rftrb_if;
  logic [7:0]  lk_addr;
  logic [31:0] lk_wdata;
  logic        lk_wr;
  logic        lk_rd;
  logic        lk_tog;
  logic [31:0] lk_rdata;
  logic        lk_rvalid;

  modport dev  (input lk_addr, lk_wdata, lk_wr, lk_rd, lk_tog, output lk_rdata, lk_rvalid);
  modport host (output lk_addr, lk_wdata, lk_wr, lk_rd, lk_tog, input lk_rdata, lk_rvalid);
endinterface : rftrb_if

// ===== logic/rftrb_pkg.sv
/*
 * Types and shared functions of the tuning register bank.
 * Assumes rftrb_consts.svh is on the include path.
 */
`include "rftrb_consts.svh"

package rftrb_pkg;

  // ****************************************************************
  // Basic types.
  // ****************************************************************
  typedef logic [`RFTRB_AW-1:0]     rftrb_addr_t;
  typedef logic [`RFTRB_DW-1:0]     rftrb_data_t;
  typedef logic [`RFTRB_RAMP_W-1:0] rftrb_ramp_t;

  typedef enum logic [1:0] {rftrb_rate_1m, rftrb_rate_2m, rftrb_rate_250k} rftrb_rate_e;
  typedef enum logic [2:0] {hs_idle, hs_chk_rd, hs_chk_wait, hs_seq, hs_raw_wait} rftrb_hst_e;

  // ****************************************************************
  // State records.
  // ****************************************************************
  typedef struct packed {
    rftrb_data_t tune3;
    rftrb_data_t tune4;
    rftrb_data_t tune5;
    rftrb_data_t tune6;
    rftrb_data_t init;
    rftrb_data_t feat;
    rftrb_data_t rdata;
    logic        rvalid;
    logic        bank_one;
    rftrb_addr_t b0_addr;
    rftrb_data_t b0_wdata;
    logic        b0_wr;
    logic        b0_rd;
    logic        b0_pend;
  } rftrb_dev_s;

  typedef struct packed {
    rftrb_data_t lo;
    rftrb_data_t mid;
    rftrb_ramp_t word;
    logic [1:0]  part;
  } rftrb_ramp_s;

  typedef struct packed {
    rftrb_hst_e  state;
    rftrb_rate_e rate;
    logic        sc;
    logic [3:0]  step;
    rftrb_addr_t raddr;
    rftrb_data_t rwdata;
    rftrb_data_t rrdata;
    logic        done;
    logic        err;
    logic        bank_one;
    rftrb_addr_t addr;
    rftrb_data_t wdata;
    logic        wr;
    logic        rd;
    logic        tog;
    rftrb_data_t sw_rdata;
  } rftrb_hst_s;

  // ****************************************************************
  // Address decode of this bank.
  // ****************************************************************
  function automatic logic rftrb_mapped(input rftrb_addr_t a);
    rftrb_mapped = (a >= `RFTRB_OFS_TUNE3 && a <= `RFTRB_OFS_ID) ||
                   (a >= `RFTRB_OFS_INIT  && a <= `RFTRB_OFS_RAMP);
  endfunction : rftrb_mapped

endpackage : rftrb_pkg

// ===== logic/rftrb_ramp_asm.sv
/*
 * Assembles the wide ramp word from three link words, low word first.
 * Assumes writes arrive one per cycle at most and clr restarts the order.
 */
`timescale 1ns/1ps
`include "rftrb_consts.svh"

module rftrb_ramp_asm (
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  input  wire logic                       wr_en,
  input  wire logic                       clr,
  input  wire logic [`RFTRB_DW-1:0]       wdata,
  output logic      [`RFTRB_RAMP_W-1:0]   ramp_word
);

  rftrb_pkg::rftrb_ramp_s s_q;
  rftrb_pkg::rftrb_ramp_s s_d;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.part = 2'h0;
    end else if (wr_en) begin
      unique case (s_q.part)
        2'h0: begin
          s_d.lo   = wdata;
          s_d.part = 2'h1;
        end
        2'h1: begin
          s_d.mid  = wdata;
          s_d.part = 2'h2;
        end
        2'h2: begin
          s_d.word = {wdata[`RFTRB_RAMP_TOP_W-1:0], s_q.mid, s_q.lo};
          s_d.part = 2'h0;
        end
        default: begin
          s_d.part = 2'h0;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ramp_word = s_q.word;

endmodule : rftrb_ramp_asm

// ===== tb/rftrb_link_chk.sv
/*
 * Link checker of the tuning register bank: watches the host-to-device link.
 * Assumes one clock, a synchronous active-low reset and the link of rftrb_if.
 */
`timescale 1ns/1ps

module rftrb_link_chk #(
  parameter logic [31:0] IDENTITY_VALUE = 32'h0000_5A5A  // Arbitrary value.
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [7:0]  lk_addr,
  input wire logic [31:0] lk_wdata,
  input wire logic        lk_wr,
  input wire logic        lk_rd,
  input wire logic        lk_tog,
  input wire logic [31:0] lk_rdata,
  input wire logic        lk_rvalid
);
  // ****************************************************************
  // Bank tracking and properties.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic bank_q;
  wire  ramp_w = lk_wr && (lk_addr == 8'h0E);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bank_q <= 1'h0;
    end else if (lk_tog) begin
      bank_q <= ~bank_q;
    end
  end

  strobe_excl_a: assert property (!(lk_wr && lk_rd) && !(lk_tog && (lk_wr || lk_rd)))
    else $error("link strobes overlap");
  read_answer_a: assert property (lk_rd |-> ##[1:3] lk_rvalid)
    else $error("link read not answered in time");
  status_word_a: assert property (lk_rd && lk_addr == 8'h07 |=> lk_rvalid &&
    lk_rdata == {24'h00_0000, bank_q, 7'h00})
    else $error("status word does not show the bank");
  id_word_a: assert property (lk_rd && lk_addr == 8'h08 && bank_q |=>
    lk_rvalid && lk_rdata == IDENTITY_VALUE)
    else $error("identity word wrong");
  status_nowrite_a: assert property (lk_wr |-> lk_addr != 8'h07)
    else $error("status word written");
  bank_map_a: assert property ((lk_wr || lk_rd) && bank_q |->
    lk_addr inside {[8'h03:8'h08], [8'h0C:8'h0E]})
    else $error("unmapped address reached the link");
  tune_load_a: assert property (lk_wr && lk_addr == 8'h03 && bank_q |-> lk_wdata == 32'h4)
    else $error("tuning word three loaded wrongly");
  init_value_a: assert property (lk_wr && lk_addr == 8'h0C && bank_q |->
    lk_wdata == 32'h0573_1200)
    else $error("lock time word loaded wrongly");
  ramp_order_a: assert property (lk_wr && lk_addr == 8'h0D |=> ramp_w &&
    lk_wdata == 32'hCF20_8104 ##1 ramp_w && lk_wdata == 32'hF7DF_7CF3
    ##1 ramp_w && lk_wdata[23:0] == 24'hCF_EFBE)
    else $error("ramp word not sent as three ordered writes");

  tog_c: cover property (lk_tog);
  id_c: cover property (lk_rd && lk_addr == 8'h08 && bank_q);
  ramp_c: cover property (ramp_w);
  zero_c: cover property (lk_rvalid && !bank_q);
endmodule : rftrb_link_chk

// ===== tb/tb_rf_tuning_register_bank.sv
/*
 * Testbench of the tuning register bank: host and device ends joined by the link.
 * Assumes the design files and the link checker are compiled before it.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, e); end end

module tb_rf_tuning_register_bank;
  // ****************************************************************
  // Signals, ends and checker.
  // ****************************************************************
  localparam logic [31:0] ID_W = 32'h0000_C3C3;  // Arbitrary value.

  logic        core_clk = 1'h0;
  logic        nrst     = 1'h0;
  logic [7:0]  sw_addr  = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr    = 1'h0;
  logic        sw_rd    = 1'h0;
  logic [31:0] b0_rdata = 32'h1234_ABCD;
  logic [31:0] sw_rdata, tune3, tune4, tune5, tune6, lock_init, feat_cfg, b0_wdata, v, st;
  logic [87:0] ramp_word;
  logic [7:0]  b0_addr;
  logic        bank_select_status;
  logic        b0_wr;
  logic        b0_rd;
  int          err_total = 0;
  int          tests_run = 0;
  int          b0_wr_n   = 0;
  int          b0_rd_n   = 0;

  always #4 core_clk = ~core_clk;

  // Counts the forwarded bank-zero strobes.
  always @(posedge core_clk) begin
    if (b0_wr === 1'h1) begin
      b0_wr_n++;
    end
    if (b0_rd === 1'h1) begin
      b0_rd_n++;
    end
  end

  rftrb_if u_rftrb_if ();
  rftrb_host u_rftrb_host (.core_clk(core_clk), .nrst(nrst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .lk(u_rftrb_if.host));
  rftrb_dev #(.IDENTITY_VALUE(ID_W)) u_rftrb_dev (.core_clk(core_clk), .nrst(nrst),
    .lk(u_rftrb_if.dev), .tune3(tune3), .tune4(tune4), .tune5(tune5), .tune6(tune6),
    .lock_init(lock_init), .feat_cfg(feat_cfg), .ramp_word(ramp_word),
    .bank_select_status(bank_select_status), .b0_addr(b0_addr), .b0_wdata(b0_wdata),
    .b0_wr(b0_wr), .b0_rd(b0_rd), .b0_rdata(b0_rdata));
  rftrb_link_chk #(.IDENTITY_VALUE(ID_W)) u_rftrb_link_chk (.core_clk(core_clk), .nrst(nrst),
    .lk_addr(u_rftrb_if.lk_addr), .lk_wdata(u_rftrb_if.lk_wdata), .lk_wr(u_rftrb_if.lk_wr),
    .lk_rd(u_rftrb_if.lk_rd), .lk_tog(u_rftrb_if.lk_tog), .lk_rdata(u_rftrb_if.lk_rdata),
    .lk_rvalid(u_rftrb_if.lk_rvalid));

  // ****************************************************************
  // Software port tasks.
  // ****************************************************************
  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'h1;
    @(posedge core_clk);
    sw_wr <= 1'h0;
  endtask : sw_write

  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd   <= 1'h1;
    @(posedge core_clk);
    sw_rd <= 1'h0;
    #1 d = sw_rdata;
  endtask : sw_read

  task automatic wait_idle;
    for (int i = 0; i < 40; i++) begin
      sw_read(8'h06, st);
      if (st[0] === 1'h0) break;
    end
  endtask : wait_idle

  task automatic raw(input logic [7:0] a, input logic [31:0] d, input logic [2:0] c);
    sw_write(8'h02, {24'h00_0000, a});
    sw_write(8'h03, d);
    sw_write(8'h04, {29'h0, c});
    wait_idle();
    sw_read(8'h05, v);
  endtask : raw

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_setup(input logic [1:0] r, input logic sc);
    logic [31:0] e4;
    logic [31:0] e5;
    e4 = sc ? (r == 2'h2 ? 32'hC37D_6D5D : 32'hC37D_5D5D)
            : (r == 2'h2 ? 32'h437D_6D5F : 32'h437D_5D5F);
    e5 = r == 2'h2 ? 32'h7410_6C9F : (r == 2'h0 ? 32'h1412_6C9F : 32'h7411_4C9F);
    sw_write(8'h00, {29'h0, sc, r});
    sw_write(8'h01, 32'h0);
    wait_idle();
    `CHK(st[2:1], 2'h3)
    `CHK(bank_select_status, 1'h1)
    `CHK(tune3, 32'h0000_0004)
    `CHK(tune4, e4)
    `CHK(tune5, e5)
    `CHK(tune6, (r == 2'h0 ? 32'h0007_C022 : 32'h0007_C002))
    `CHK(lock_init, 32'h0573_1200)
    `CHK(feat_cfg, (r == 2'h2 ? 32'h0080_B436 : 32'h0080_B434))
    `CHK(ramp_word, 88'hCF_EFBE_F7DF_7CF3_CF20_8104)
  endtask : t_setup

  task automatic t_regs;
    raw(8'h08, 32'h0, 3'h2);
    `CHK(v, ID_W)
    raw(8'h08, ~ID_W, 3'h1);
    raw(8'h08, 32'h0, 3'h2);
    `CHK(v, ID_W)
    raw(8'h07, 32'h0, 3'h2);
    `CHK(v, 32'h0000_0080)
    raw(8'h0A, 32'h0, 3'h1);
    `CHK(st[3], 1'h1)
    sw_write(8'h06, 32'h0000_0008);
    sw_read(8'h06, st);
    `CHK(st[3], 1'h0)
    raw(8'h00, 32'h0, 3'h4);
    `CHK(bank_select_status, 1'h0)
    raw(8'h04, 32'hA5A5_0F0F, 3'h1);
    `CHK(tune4, 32'hC37D_6D5D)
    `CHK({b0_addr, b0_wdata}, 40'h04_A5A5_0F0F)
    `CHK(b0_wr_n, 1)
    raw(8'h05, 32'h0, 3'h2);
    `CHK(v, 32'h1234_ABCD)
    `CHK(b0_rd_n, 1)
    raw(8'h07, 32'h0, 3'h2);
    `CHK(v, 32'h0)
    `CHK(b0_rd_n, 1)
  endtask : t_regs

  task automatic t_reset;
    repeat (12) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    #1;
    `CHK(tune3, 32'h0300_1200)
    `CHK({tune4, tune5, tune6, lock_init, feat_cfg}, 160'h0)
    `CHK(bank_select_status, 1'h0)
  endtask : t_reset

  task automatic finish_test;
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    finish_test();
  end

  initial begin
    t_reset();
    for (int k = 0; k < 6; k++) begin
      t_setup(2'(k % 3), 1'(k / 3));
    end
    t_regs();
    finish_test();
  end
endmodule : tb_rf_tuning_register_bank
